/* hw/cbt_bit_timer.sv */
// Time quantum prescaler and bit segment sequencer with resynchronisation
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timer import cbt_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Settings
   input wire logic run,
   input wire logic rxLevel,
   input wire logic [9:0] tqDiv,
   input wire logic [3:0] pp1,
   input wire logic [2:0] ph2,
   input wire logic [2:0] sjw,
   // Timing
   output logic tqTick,
   output logic bitStart,
   output logic samplePulse,
   output logic sampledBit
);
   cbt_bt_s r_reg;
   cbt_bt_s r_next;
   logic tick;
   logic fallEdge;

   always_comb begin
      r_next = r_reg;
      r_next.tqTick = 1'b0;
      r_next.bitStart = 1'b0;
      r_next.samplePulse = 1'b0;
      tick = run && (r_reg.divCnt + 10'h001 >= tqDiv); // RL3
      fallEdge = run && r_reg.rxPrev && !rxLevel;
      // Disabled: everything freezes so an enable resumes in place
      if (run) begin
         r_next.rxPrev = rxLevel;
         r_next.divCnt = tick ? 10'h000 : r_reg.divCnt + 10'h001;
      end
      if (tick) begin
         r_next.tqTick = 1'b1;
         r_next.tqCnt = r_reg.tqCnt + 5'h01;
         case (r_reg.seg)
            CBT_SYNC: begin
               r_next.seg = CBT_SEG1; // RL2
               r_next.tqCnt = 5'h00;
               r_next.seg1Len = {1'b0, pp1};
            end
            CBT_SEG1: begin
               if (r_reg.tqCnt + 5'h01 >= r_reg.seg1Len) begin
                  r_next.seg = CBT_SEG2;
                  r_next.tqCnt = 5'h00;
                  r_next.samplePulse = 1'b1;
                  r_next.sampledBit = rxLevel;
               end
            end
            default: begin
               if (r_reg.tqCnt + 5'h01 >= {2'b00, ph2}) begin
                  r_next.seg = CBT_SYNC; // RL1
                  r_next.tqCnt = 5'h00;
                  r_next.bitStart = 1'b1;
               end
            end
         endcase
      end
      // Late edge stretches phase one, early edge cuts phase two
      if (fallEdge && r_reg.seg == CBT_SEG1) begin
         r_next.seg1Len = r_reg.seg1Len + {2'b00, sjw}; // RL14
      end else if (fallEdge && r_reg.seg == CBT_SEG2) begin
         if ({2'b00, ph2} - r_reg.tqCnt <= {2'b00, sjw}) begin
            r_next.seg = CBT_SEG1;
            r_next.tqCnt = 5'h00;
            r_next.divCnt = 10'h000;
            r_next.seg1Len = {1'b0, pp1};
            r_next.bitStart = 1'b1;
         end else begin
            r_next.tqCnt = r_reg.tqCnt + {2'b00, sjw}; // RL14
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '{seg: CBT_SYNC, rxPrev: 1'b1, sampledBit: 1'b1,
            default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign tqTick = r_reg.tqTick;
   assign bitStart = r_reg.bitStart;
   assign samplePulse = r_reg.samplePulse;
   assign sampledBit = r_reg.sampledBit;

   // Checker helpers: quanta per bit and cycles per quantum
   logic [4:0] qCnt;
   logic edgeSeen;
   logic [10:0] gap;
   logic gapValid;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         qCnt <= 5'h00;
         edgeSeen <= 1'b1;
         gap <= 11'h000;
         gapValid <= 1'b0;
      end else begin
         if (bitStart) begin
            qCnt <= 5'h00;
            // A resync restart skips the sync quantum
            edgeSeen <= fallEdge || r_reg.seg != CBT_SYNC;
         end else begin
            qCnt <= qCnt + {4'h0, tqTick};
            // Settings may change during a pause
            edgeSeen <= edgeSeen || fallEdge || !run;
         end
         gap <= tqTick ? 11'h001 : gap + 11'h001;
         // An early edge within the jump width of the bit end restarts the quantum
         gapValid <= run && !fallEdge && (gapValid || tqTick);
      end
   end

   AST_BIT_LEN: assert property ( // RL1
      @(posedge clock) disable iff (!rst_n)
      (bitStart && tqTick && !edgeSeen) |->
         qCnt + 5'h01 == {1'b0, pp1} + {2'b00, ph2} + 5'h01)
      else $error("bit length differs from settings");
   AST_SYNC_ONE: assert property ( // RL2
      @(posedge clock) disable iff (!rst_n)
      (samplePulse && !edgeSeen) |-> qCnt + 5'h01 == {1'b0, pp1} + 5'h01)
      else $error("sync segment not one quantum");
   AST_TQ_GAP: assert property ( // RL3
      @(posedge clock) disable iff (!rst_n)
      (tqTick && gapValid && $stable(tqDiv)) |-> gap == {1'b0, tqDiv})
      else $error("quantum length differs from divider");
   AST_SJW_EXT: assert property ( // RL14
      @(posedge clock) disable iff (!rst_n)
      (fallEdge && r_reg.seg == CBT_SEG1) |=>
         r_reg.seg1Len == $past(r_reg.seg1Len) + {2'b00, $past(sjw)})
      else $error("phase one not stretched by jump width");
endmodule : cbt_bit_timer
`default_nettype wire

/* hw/cbt_can_ctrl.sv */
// CAN core control: registers, enable, bit timing, error counts, interrupts
// Functional notes
// [RL1] Bit length in quanta is phase-one setting plus phase-two setting plus one.
// [RL2] Sync segment lasts exactly one quantum; the whole first setting is prop/phase one.
// [RL3] Quantum is clock divided by prescaler; bit rate follows from both.
// [RL4] Controller is disabled after reset until software enables it.
// [RL5] Software clears all message objects before the first enable.
// [RL6] Disabling stops bus processing but keeps all state for resuming.
// [RL7] Once enabled, pending frames are sent and incoming frames processed.
// [RL8] Software sets bit timing and initialises before enabling.
// [RL9] Error counts readable with a receive error-passive flag.
// [RL10] Interrupt clear takes status cause code or object number 1 to 32.
// [RL11] Reading the status register clears the pending status interrupt.
// [RL12] Transferring an object to the host may clear its pending interrupt.
// [RL13] Interrupt only from sources whose individual enable bits are set.
// [RL14] Resynchronisation jump width programmable from 1 to 4 quanta.
// [RL15] Quantum prescaler accepts 1 up to 1023.
// [RL16] Global enable gates every interrupt of the controller.
// [RL17] Error interrupts on bus-off entry or warning or passive limit.
// [RL18] Error counters follow CAN fault confinement rules.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_can_ctrl import cbt_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,

   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [31:0] rdData,

   // Bus pin
   input wire logic canRx,

   // Protocol engine events
   input wire logic evTxOk,
   input wire logic evRxOk,
   input wire logic evLecValid,
   input wire logic [2:0] evLec,
   input wire logic evTxErr,
   input wire logic evRxErr,
   input wire logic evRxErr8,
   input wire logic evRecover,
   input wire logic txPending,

   // Message object interrupt sources
   input wire logic [31:0] objIntSet,
   input wire logic objXferClr,
   input wire logic [5:0] objXferNum,

   // Status and timing
   output logic ctlEnabled,
   output logic txGo,
   output logic tqTick,
   output logic bitStart,
   output logic samplePulse,
   output logic sampledBit,
   output logic irq
);
   localparam cbt_top_s TOP_RST = '{
      tqDiv: `CBT_DIV_RST,
      pp1: `CBT_PP1_RST,
      ph2: `CBT_PH2_RST,
      mask: `CBT_MASK_RST,
      rxSync: 3'h7,
      rxLevel: 1'b1,
      default: '0
   };

   cbt_top_s r_reg;
   cbt_top_s r_next;
   cbt_err_if eIf ();

   logic en;
   logic lecEvt;

   logic passIn;
   logic warnIn;
   logic boffIn;

   logic [8:0] stsSet;
   logic [8:0] ieVec;
   logic stsPend;
   logic stsClr;

   logic [31:0] objSetG;
   logic [31:0] objClr;
   logic [31:0] rdVal;

   // ==========================================================
   // Decoding helpers
   // ==========================================================
   function automatic logic [31:0] objMask(input logic [31:0] num);
      objMask = 32'h0000_0000;
      if (num >= 32'h1 && num <= 32'h20) begin
         objMask = 32'h0000_0001 << (num - 32'h1);
      end
   endfunction : objMask

   // Lowest numbered object has the highest priority
   function automatic logic [31:0] objPrio(input logic [31:0] pend);
      int i;
      objPrio = 32'h0000_0000;
      for (i = 31; i >= 0; i--) begin
         if (pend[i]) begin
            objPrio = i + 1;
         end
      end
   endfunction : objPrio

   // ==========================================================
   // Event gating and interrupt sources
   // ==========================================================
   assign en = r_reg.ctlEn;
   assign lecEvt = en && evLecValid;
   // Engine events are ignored while disabled
   assign eIf.txErr = en && evTxErr; // RL6
   assign eIf.rxErr = en && evRxErr;
   assign eIf.rxErr8 = en && evRxErr8;
   assign eIf.txOk = en && evTxOk;
   assign eIf.rxOk = en && evRxOk;
   assign eIf.recover = en && evRecover;

   assign passIn = eIf.ePass && !r_reg.prevPass; // RL17
   assign warnIn = eIf.eWarn && !r_reg.prevWarn; // RL17
   assign boffIn = eIf.busOff && !r_reg.prevBoff; // RL17
   assign stsSet = {lecEvt, boffIn, warnIn, passIn, eIf.rxOk, eIf.txOk,
      3'h0};
   assign ieVec = (r_reg.stsIe ? `CBT_STS_BITS : 9'h000) |
      (r_reg.errIe ? `CBT_ERR_BITS : 9'h000); // RL13
   assign stsPend = |(r_reg.sts & r_reg.mask & ieVec); // RL13

   assign objSetG = en ? objIntSet : 32'h0000_0000;
   assign stsClr = (rdStrobe && addr == `CBT_OFF_STAT) || // RL11
      (wrStrobe && addr == `CBT_OFF_INTID &&
      wdata == `CBT_STATUS_CAUSE); // RL10
   assign objClr = (wrStrobe && addr == `CBT_OFF_INTID ?
      objMask(wdata) : 32'h0000_0000) | // RL10
      (objXferClr ? objMask({26'h0, objXferNum}) : 32'h0000_0000); // RL12

   // ==========================================================
   // Register read mux
   // ==========================================================
   always_comb begin
      rdVal = 32'h0000_0000;
      if (addr == `CBT_OFF_CTRL) begin
         rdVal = {28'h0, r_reg.stsIe, r_reg.errIe, r_reg.master, r_reg.ctlEn};
      end else if (addr == `CBT_OFF_STAT) begin
         rdVal = {23'h0, r_reg.sts};
      end else if (addr == `CBT_OFF_BTIM) begin
         rdVal = {9'h0, r_reg.ph2, r_reg.pp1, 2'h0, r_reg.sjwCode, 2'h0,
            r_reg.tqDiv};
      end else if (addr == `CBT_OFF_ERRC) begin
         rdVal = {14'h0, eIf.busOff, eIf.rxPassive, eIf.rec, eIf.tec}; // RL9
      end else if (addr == `CBT_OFF_INTID) begin
         rdVal = stsPend ? `CBT_STATUS_CAUSE : objPrio(r_reg.objPend);
      end else if (addr == `CBT_OFF_OBJP) begin
         rdVal = r_reg.objPend;
      end else if (addr == `CBT_OFF_MASK) begin
         rdVal = {23'h0, r_reg.mask};
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      r_next = r_reg;
      // Pin synchroniser: rxLevel only moves when stages two and three agree
      r_next.rxSync = {r_reg.rxSync[1:0], canRx};
      if (r_reg.rxSync[1] == r_reg.rxSync[2]) begin
         r_next.rxLevel = r_reg.rxSync[2];
      end

      r_next.prevPass = eIf.ePass;
      r_next.prevWarn = eIf.eWarn;
      r_next.prevBoff = eIf.busOff;
      // New events win over a clear in the same cycle
      r_next.sts = (stsClr ? 9'h000 : r_reg.sts) | stsSet;
      if (lecEvt) begin
         r_next.sts[2:0] = evLec;
      end

      r_next.objPend = (r_reg.objPend & ~objClr) | objSetG;
      if (wrStrobe) begin
         if (addr == `CBT_OFF_CTRL) begin
            r_next.ctlEn = wdata[`CBT_CTRL_EN];
            r_next.master = wdata[`CBT_CTRL_MASTER];
            r_next.errIe = wdata[`CBT_CTRL_ERRIE];
            r_next.stsIe = wdata[`CBT_CTRL_STSIE];
         end else if (addr == `CBT_OFF_BTIM) begin
            // A zero divider would tick every clock like one, so it reads as one
            r_next.tqDiv = wdata[9:0] == 10'h000 ? 10'h001 : wdata[9:0]; // RL15
            r_next.sjwCode = wdata[13:12]; // RL14
            r_next.pp1 = wdata[19:16];
            r_next.ph2 = wdata[22:20];
         end else if (addr == `CBT_OFF_MASK) begin
            r_next.mask = wdata[8:0];
         end
      end

      r_next.rdData = rdStrobe ? rdVal : 32'h0000_0000;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= TOP_RST; // RL4
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Datapath blocks
   // ==========================================================
   cbt_bit_timer u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .run(en), // RL6
      .rxLevel(r_reg.rxLevel),
      .tqDiv(r_reg.tqDiv),
      .pp1(r_reg.pp1),
      .ph2(r_reg.ph2),
      .sjw({1'b0, r_reg.sjwCode} + 3'h1), // RL14
      .tqTick(tqTick),
      .bitStart(bitStart),
      .samplePulse(samplePulse),
      .sampledBit(sampledBit)
   );

   cbt_err_counter u_errs (
      .clock(clock),
      .rst_n(rst_n),
      .e(eIf.cnt)
   );

   assign rdData = r_reg.rdData;
   assign ctlEnabled = en;
   assign txGo = en && txPending; // RL7
   assign irq = r_reg.master && (stsPend || |r_reg.objPend); // RL16

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_IRQ_MASTER: assert property ( // RL16
      !r_reg.master |-> !irq)
      else $error("interrupt without global enable");

   AST_IRQ_SOURCE: assert property ( // RL13
      (irq && r_reg.objPend == 32'h0) |->
         |(r_reg.sts & r_reg.mask & ieVec))
      else $error("interrupt from a disabled source");

   AST_STS_RDCLR: assert property ( // RL11
      (rdStrobe && addr == `CBT_OFF_STAT && stsSet == 9'h000 && !lecEvt)
         |=> r_reg.sts == 9'h000 && !stsPend)
      else $error("status read did not clear status");

   AST_CAUSE_CLR: assert property ( // RL10
      (wrStrobe && addr == `CBT_OFF_INTID && wdata == `CBT_STATUS_CAUSE &&
         stsSet == 9'h000) |=> !stsPend)
      else $error("cause write did not clear status interrupt");

   AST_OBJ_CLR: assert property ( // RL10
      (objClr != 32'h0 && (objClr & objSetG) == 32'h0) |=>
         (r_reg.objPend & $past(objClr)) == 32'h0)
      else $error("object interrupt not cleared");

   AST_XFER_CLR: assert property ( // RL12
      (objXferClr && objSetG == 32'h0) |=>
         (r_reg.objPend & objMask({26'h0, $past(objXferNum)})) == 32'h0)
      else $error("transfer did not clear object interrupt");

   AST_DIS_FREEZE: assert property ( // RL6
      !en |=> $stable(eIf.tec) && $stable(eIf.rec) && !bitStart)
      else $error("disabled controller changed state");

   AST_RXPASS: assert property ( // RL9
      (rdStrobe && addr == `CBT_OFF_ERRC) |=>
         rdData[16] == (rdData[15:8] >= 8'h80))
      else $error("passive flag disagrees with count");

   AST_DIV_NZ: assert property ( // RL15
      r_reg.tqDiv != 10'h000 ##1 r_reg.tqDiv != 10'h000)
      else $error("prescaler left at zero");

   AST_ERR_IRQ: assert property ( // RL17
      (boffIn && r_reg.errIe && r_reg.master && r_reg.mask[`CBT_ST_BOFF])
         |=> irq)
      else $error("bus-off entry raised no interrupt");

   COV_IRQ: cover property ($rose(irq));
   COV_BOFF: cover property (boffIn);
   COV_SAMPLE: cover property (samplePulse && !sampledBit);
   COV_XFER: cover property (objXferClr && |r_reg.objPend);
endmodule : cbt_can_ctrl
`default_nettype wire

/* hw/cbt_err_counter.sv */
// Transmit and receive error counters with fault confinement states
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"
module cbt_err_counter import cbt_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Events and counts
   cbt_err_if.cnt e
);
   cbt_ec_s r_reg;
   cbt_ec_s r_next;
   logic [8:0] recSum;

   always_comb begin
      r_next = r_reg;
      recSum = {1'b0, r_reg.rec};
      if (r_reg.busOff) begin
         // Only the recovery sequence leaves bus-off
         if (e.recover) begin
            r_next = '0;
         end
      end else begin
         if (e.txErr) begin
            r_next.tec = r_reg.tec + `CBT_TEC_STEP; // RL18
         end else if (e.txOk && r_reg.tec != 9'h000) begin
            r_next.tec = r_reg.tec - 9'h001; // RL18
         end
         if (e.rxErr8) begin
            recSum = {1'b0, r_reg.rec} + `CBT_REC_STEP;
         end else if (e.rxErr) begin
            recSum = {1'b0, r_reg.rec} + 9'h001;
         end else if (e.rxOk && r_reg.rec > `CBT_REC_CAP) begin
            recSum = {1'b0, `CBT_REC_CAP};
         end else if (e.rxOk && r_reg.rec != 8'h00) begin
            recSum = {1'b0, r_reg.rec} - 9'h001;
         end
         // Saturate rather than wrap back to error active
         r_next.rec = recSum[8] ? 8'hFF : recSum[7:0]; // RL18
         if (r_next.tec >= `CBT_LIM_BOFF) begin
            r_next.busOff = 1'b1; // RL18
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign e.tec = r_reg.busOff ? 8'hFF : r_reg.tec[7:0];
   assign e.rec = r_reg.rec;
   assign e.busOff = r_reg.busOff;
   assign e.rxPassive = {1'b0, r_reg.rec} >= `CBT_LIM_PASS; // RL9
   assign e.ePass = e.rxPassive || r_reg.tec >= `CBT_LIM_PASS;
   assign e.eWarn = {1'b0, r_reg.rec} >= `CBT_LIM_WARN ||
      r_reg.tec >= `CBT_LIM_WARN;

   AST_TEC_INC: assert property ( // RL18
      @(posedge clock) disable iff (!rst_n)
      (e.txErr && !r_reg.busOff) |=>
         r_reg.tec == $past(r_reg.tec) + `CBT_TEC_STEP)
      else $error("transmit error did not add eight");
   AST_BOFF_LIMIT: assert property ( // RL18
      @(posedge clock) disable iff (!rst_n)
      (r_reg.tec >= `CBT_LIM_BOFF) |-> r_reg.busOff)
      else $error("count past limit without bus-off");
endmodule : cbt_err_counter
`default_nettype wire

/* hw/cbt_err_if.sv */
// Error events into, and counter state out of, the fault confinement counter
`timescale 1ns/1ps
`default_nettype none
interface cbt_err_if;
   logic txErr;
   logic rxErr;
   logic rxErr8;
   logic txOk;
   logic rxOk;
   logic recover;
   logic [7:0] tec;
   logic [7:0] rec;
   logic busOff;
   logic ePass;
   logic eWarn;
   logic rxPassive;
   modport ctl (output txErr, rxErr, rxErr8, txOk, rxOk, recover,
      input tec, rec, busOff, ePass, eWarn, rxPassive);
   modport cnt (input txErr, rxErr, rxErr8, txOk, rxOk, recover,
      output tec, rec, busOff, ePass, eWarn, rxPassive);
endinterface : cbt_err_if
`default_nettype wire

/* hw/cbt_params.svh */
// Register map, field positions, reset values and limits of the CAN core
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
`define CBT_OFF_CTRL 8'h00
`define CBT_OFF_STAT 8'h04
`define CBT_OFF_BTIM 8'h08
`define CBT_OFF_ERRC 8'h0C
`define CBT_OFF_INTID 8'h10
`define CBT_OFF_OBJP 8'h14
`define CBT_OFF_MASK 8'h18
`define CBT_CTRL_EN 0
`define CBT_CTRL_MASTER 1
`define CBT_CTRL_ERRIE 2
`define CBT_CTRL_STSIE 3
`define CBT_ST_BOFF 7
`define CBT_STS_BITS 9'h118
`define CBT_ERR_BITS 9'h0E0
`define CBT_MASK_RST 9'h1F8
`define CBT_DIV_RST 10'h001
`define CBT_PP1_RST 4'h4
`define CBT_PH2_RST 3'h2
`define CBT_STATUS_CAUSE 32'h0000_8000
`define CBT_LIM_WARN 9'h060
`define CBT_LIM_PASS 9'h080
`define CBT_LIM_BOFF 9'h100
`define CBT_TEC_STEP 9'h008
`define CBT_REC_STEP 9'h008
`define CBT_REC_CAP 8'h7F
`endif

/* hw/cbt_pkg.sv */
// Types shared by the CAN bit timing and interrupt control core
package cbt_pkg;
   typedef enum logic [1:0] {
      CBT_SYNC = 2'b00,
      CBT_SEG1 = 2'b01,
      CBT_SEG2 = 2'b10
   } cbt_seg_e;
   typedef struct packed {
      cbt_seg_e seg;
      logic [9:0] divCnt;
      logic [4:0] tqCnt;
      logic [4:0] seg1Len;
      logic rxPrev;
      logic tqTick;
      logic bitStart;
      logic samplePulse;
      logic sampledBit;
   } cbt_bt_s;
   typedef struct packed {
      logic [8:0] tec;
      logic [7:0] rec;
      logic busOff;
   } cbt_ec_s;
   typedef struct packed {
      logic ctlEn;
      logic master;
      logic errIe;
      logic stsIe;
      logic [9:0] tqDiv;
      logic [1:0] sjwCode;
      logic [3:0] pp1;
      logic [2:0] ph2;
      logic [8:0] mask;
      logic [8:0] sts;
      logic [31:0] objPend;
      logic [31:0] rdData;
      logic [2:0] rxSync;
      logic rxLevel;
      logic prevPass;
      logic prevWarn;
      logic prevBoff;
   } cbt_top_s;
endpackage : cbt_pkg

/* tb/can_bit_timing_and_interrupt_control_tb.sv */
// Self-checking bench of the CAN bit timing and interrupt core
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_and_interrupt_control_tb import cbt_pkg::*;;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wrStrobe = 1'b0;
   logic rdStrobe = 1'b0;
   logic [31:0] rdData;
   logic canRx;
   logic [6:0] ev = 7'h00;
   logic [2:0] evLec = 3'h0;
   logic txPending = 1'b0;
   logic [31:0] objIntSet = 32'h0;
   logic objXferClr = 1'b0;
   logic [5:0] objXferNum = 6'h00;
   logic ctlEnabled, txGo, tqTick, bitStart, samplePulse, sampledBit, irq;
   logic nodeGo = 1'b0;
   logic [15:0] nodeLen = 16'h0000;
   logic [31:0] seed = 32'h36E6A5DA;
   int n_mismatch = 0;
   int checks = 0;
   initial forever #12.5 clock = ~clock;
   cbt_bus_node i_node (.clock(clock), .start(nodeGo), .lowLen(nodeLen),
      .canRx(canRx));
   cbt_can_ctrl i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .rdData(rdData), .canRx(canRx), .evRxOk(ev[0]), .evTxErr(ev[1]),
      .evRxErr8(ev[2]), .evTxOk(ev[3]), .evRxErr(ev[4]),
      .evLecValid(ev[5]), .evRecover(ev[6]), .evLec(evLec),
      .txPending(txPending), .objIntSet(objIntSet),
      .objXferClr(objXferClr), .objXferNum(objXferNum),
      .ctlEnabled(ctlEnabled), .txGo(txGo), .tqTick(tqTick),
      .bitStart(bitStart), .samplePulse(samplePulse),
      .sampledBit(sampledBit), .irq(irq));
   // ==========================================================
   // Helpers; wr, rd, evp and bt start and end in a rising-edge step
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wrStrobe <= 1'b1;
      @(posedge clock);
      wrStrobe <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string n);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clock);
      rdStrobe <= 1'b0;
      #1;
      chk(n, e, rdData);
      @(posedge clock);
   endtask : rd
   // One-cycle event pulses with a gap, then one edge to settle flags
   task automatic evp(input int k, input int n);
      repeat (n) begin
         ev <= 7'h01 << k;
         @(posedge clock);
         ev <= 7'h00;
         @(posedge clock);
      end
      @(posedge clock);
   endtask : evp
   // Measures one bit period from bit start to bit start
   task automatic bt(input int dv, input int p1, input int p2);
      int c;
      int t0;
      int n;
      int tk;
      n = 0;
      t0 = 0;
      tk = 0;
      for (c = 0; c < 400 && n < 2; c++) begin
         @(negedge clock);
         if (n == 1 && samplePulse === 1'b1)
            chk("sample point", (1 + p1) * dv, c - t0);
         if (n == 1 && tqTick === 1'b1)
            tk++;
         if (bitStart === 1'b1) begin
            if (n == 1)
               chk("bit clocks", (1 + p1 + p2) * dv, c - t0);
            n++;
            t0 = c;
         end
      end
      chk("bit quanta", 1 + p1 + p2, tk);
      @(posedge clock);
   endtask : bt
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #(25 * 60000);
      n_mismatch++;
      complete_run();
   end
   // ==========================================================
   // Main sequence
   initial begin
      int a;
      int b;
      int i;
      logic [31:0] bw;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk("sampledBit", 1, sampledBit);
      rd(8'h00, 32'h0, "CTRL");
      rd(8'h08, 32'h0024_0001, "BTIM");
      rd(8'h18, 32'h1F8, "MASK");
      rd(8'h1C, 32'h0, "unmapped");
      txPending <= 1'b1;
      evp(1, 3);
      rd(8'h0C, 32'h0, "ERRC off");
      chk("txGo off", 0, txGo);
      wr(8'h08, 32'h0024_0000);
      rd(8'h08, 32'h0024_0001, "div zero");
      wr(8'h08, 32'h0024_03FF);
      rd(8'h08, 32'h0024_03FF, "div max");
      // Object sources stay quiet until the controller is set up
      objIntSet <= 32'h0;
      for (i = 0; i < 4; i++) begin
         bw = {9'h0, 3'(rnd() % 4 + 1), 4'(rnd() % 6 + 2), 2'b00,
            2'(rnd()), 2'b00, (i == 0) ? 10'h001 : 10'(rnd() % 3 + 1)};
         wr(8'h00, 32'h0);
         wr(8'h08, bw);
         rd(8'h08, bw, "BTIM");
         wr(8'h00, 32'h1);
         chk("txGo on", 1, txGo);
         chk("ctlEnabled", 1, ctlEnabled);
         bt(bw[9:0], bw[19:16], bw[22:20]);
      end
      wr(8'h00, 32'h7);
      evp(1, 12);
      chk("irq warn", 1, irq);
      rd(8'h0C, 32'h60, "ERRC tec");
      wr(8'h00, 32'h6);
      evp(1, 5);
      rd(8'h0C, 32'h60, "ERRC held");
      wr(8'h00, 32'h7);
      rd(8'h04, 32'h40, "STAT warn");
      chk("irq read", 0, irq);
      evp(1, 4);
      rd(8'h04, 32'h20, "STAT pass");
      evp(2, 15);
      evp(4, 8);
      rd(8'h0C, 32'h0001_8080, "ERRC passive");
      evp(0, 1);
      rd(8'h0C, 32'h7F80, "ERRC rxok");
      wr(8'h00, 32'h3);
      evp(1, 16);
      chk("irq noerrie", 0, irq);
      rd(8'h0C, 32'h0002_7FFF, "ERRC busoff");
      wr(8'h00, 32'h7);
      chk("irq busoff", 1, irq);
      wr(8'h00, 32'h5);
      chk("irq nomaster", 0, irq);
      wr(8'h10, 32'h8000);
      wr(8'h00, 32'h7);
      rd(8'h04, 32'h0, "STAT cleared");
      evp(6, 1);
      rd(8'h0C, 32'h0, "ERRC recover");
      wr(8'h00, 32'hB);
      a = rnd() % 6 + 1;
      evLec <= 3'(a);
      evp(3, 1);
      evp(5, 1);
      chk("irq status", 1, irq);
      wr(8'h18, 32'h0);
      chk("irq masked", 0, irq);
      rd(8'h04, 32'h108 | a, "STAT lec");
      wr(8'h18, 32'h1F8);
      a = rnd() % 16;
      b = rnd() % 16 + 16;
      objIntSet <= (32'h1 << a) | (32'h1 << b);
      @(posedge clock);
      objIntSet <= 32'h0;
      repeat (2) @(posedge clock);
      chk("irq object", 1, irq);
      rd(8'h14, (32'h1 << a) | (32'h1 << b), "OBJP");
      rd(8'h10, a + 1, "INTID low");
      wr(8'h10, a + 1);
      wr(8'h10, 33);
      rd(8'h10, b + 1, "INTID next");
      objXferNum <= 6'(b + 1);
      objXferClr <= 1'b1;
      @(posedge clock);
      objXferClr <= 1'b0;
      @(posedge clock);
      rd(8'h10, 32'h0, "INTID none");
      chk("irq idle", 0, irq);
      nodeLen <= 16'd120;
      nodeGo <= 1'b1;
      @(posedge clock);
      nodeGo <= 1'b0;
      for (i = 0; i < 400 && !(samplePulse === 1'b1 &&
         sampledBit === 1'b0); i++) @(negedge clock);
      chk("rx dominant", 0, sampledBit);
      @(posedge clock);
      complete_run();
   end
endmodule : can_bit_timing_and_interrupt_control_tb
`default_nettype wire

/* tb/cbt_bus_node.sv */
// Other node on the shared bus, pulling the line dominant on request
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
   // Clock
   input wire logic clock,
   // Request
   input wire logic start,
   input wire logic [15:0] lowLen,
   // Bus line
   output logic canRx
);
   logic [15:0] left = 16'h0000;
   always_ff @(posedge clock) begin
      if (start)
         left <= lowLen;
      else if (left != 16'h0000)
         left <= left - 16'h0001;
   end
   // Pull-up makes the line recessive whenever no node drives it
   assign canRx = (left == 16'h0000);
endmodule : cbt_bus_node
`default_nettype wire
